// ### logic/elc_defs.svh
// Offsets, field positions and reset values of the external link control block
`ifndef ELC_DEFS_SVH
`define ELC_DEFS_SVH

// Link count and configuration register indices
`define ELC_NLINK      8
`define ELC_CTRL_BASE  8'h80
`define ELC_CTRL_LAST  8'h87
`define ELC_FWD_BASE   8'hA0
`define ELC_FWD_LAST   8'hA7

// Link control and status fields
`define ELC_B_EN       31
`define ELC_B_FIVE     30
`define ELC_B_ERR      27
`define ELC_B_RXCR     26
`define ELC_B_TXCR     25
`define ELC_B_INIT     24
`define ELC_B_RXRST    23
`define ELC_SYM_HI     21
`define ELC_SYM_LO     11
`define ELC_TOK_HI     10
`define ELC_TOK_LO     0

// Static forwarding fields
`define ELC_B_FWD_EN   31
`define ELC_CE_HI      4
`define ELC_CE_LO      0

// Reset values
`define ELC_GAP_RST    11'h000
`define ELC_CE_RST     5'h00
`define ELC_WORD_RST   32'h0000_0000

`endif

// ### logic/elc_pkg.sv
// Types shared by the external link control block
package elc_pkg;
  typedef logic [10:0] elc_gap_t;
  typedef logic [4:0]  elc_ce_t;
  typedef logic [31:0] elc_word_t;
  // Which register group an access hits
  typedef enum logic [1:0] {ELC_SEL_NONE, ELC_SEL_CTRL, ELC_SEL_FWD} elc_sel_e;
endpackage

// ### logic/elc_cfg_if.sv
// Per-link carrier between the register file and one link unit
`timescale 1ns/1ps
`default_nettype none
interface elc_cfg_if;
  import elc_pkg::*;
  logic     en;
  logic     five;
  elc_gap_t sym_gap;
  elc_gap_t tok_gap;
  logic     init_cmd;
  logic     rxrst_cmd;
  logic     rd_clr;
  logic     err;
  logic     tx_credit;
  logic     rx_credit;
  modport ctl  (output en, five, sym_gap, tok_gap, init_cmd, rxrst_cmd, rd_clr,
                input  err, tx_credit, rx_credit);
  modport unit (input  en, five, sym_gap, tok_gap, init_cmd, rxrst_cmd, rd_clr,
                output err, tx_credit, rx_credit);
endinterface
`default_nettype wire

// ### logic/elc_link_unit.sv
// One external link: error flag, credit state, commands and transmit pacing
`include "elc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module elc_link_unit
  import elc_pkg::*;
(
  // Clock and reset
  input  wire logic  mclk_i,
  input  wire logic  rstn_i,
  // Register side
  elc_cfg_if.unit    cfg,
  // Link datapath events
  input  wire logic  rx_overflow_i,
  input  wire logic  rx_bad_token_i,
  input  wire logic  credit_rcvd_i,
  input  wire logic  rx_credit_out_i,
  input  wire logic  tx_in_token_i,
  input  wire logic  tx_token_end_i,
  // Link datapath controls
  output logic       credit_req_o,
  output logic       rx_resync_o,
  output logic       tx_sym_step_o,
  output logic       tx_tok_ready_o
);
  logic     err_ff, txcr_ff, rxcr_ff;
  elc_gap_t sym_cnt_ff, tok_cnt_ff;
  logic [11:0] sym_nxt, tok_nxt;
  logic     err_ev, sym_hit, tok_hit;

  // Error events and pacing compares
  assign err_ev  = rx_overflow_i | rx_bad_token_i;
  assign sym_nxt = {1'b0, sym_cnt_ff} + 12'h001;
  assign tok_nxt = {1'b0, tok_cnt_ff} + 12'h001;
  assign sym_hit = sym_nxt >= {1'b0, cfg.sym_gap};
  assign tok_hit = tok_nxt >= {1'b0, cfg.tok_gap};
  assign cfg.err       = err_ff;
  assign cfg.tx_credit = txcr_ff;
  assign cfg.rx_credit = rxcr_ff;

  // Sticky error; a new event beats the clear on read
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) err_ff <= 1'b0;
    else if (err_ev) err_ff <= 1'b1;       // [R4]
    else if (cfg.rd_clr) err_ff <= 1'b0;   // [R5]
  end

  // Credit state; credit that lands with the init strobe, a cycle after the init write, is kept
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      txcr_ff <= 1'b0;
      rxcr_ff <= 1'b0;
    end else begin
      rxcr_ff <= rx_credit_out_i;                      // [R6]
      if (credit_rcvd_i) txcr_ff <= 1'b1;              // [R7]
      else if (cfg.init_cmd) txcr_ff <= 1'b0;          // [R8]
    end
  end

  // One-shot commands toward the link datapath
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      credit_req_o <= 1'b0;
      rx_resync_o  <= 1'b0;
    end else begin
      credit_req_o <= cfg.init_cmd;    // [R8]
      rx_resync_o  <= cfg.rxrst_cmd;   // [R10]
    end
  end

  // Symbol spacing: one step per gap cycles, at most every cycle
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sym_cnt_ff    <= `ELC_GAP_RST;
      tx_sym_step_o <= 1'b0;
    end else if (!(cfg.en && tx_in_token_i)) begin
      sym_cnt_ff    <= `ELC_GAP_RST;
      tx_sym_step_o <= 1'b0;
    end else begin
      sym_cnt_ff    <= sym_hit ? `ELC_GAP_RST : sym_nxt[10:0];   // [R11]
      tx_sym_step_o <= sym_hit;
    end
  end

  // Token spacing: ready falls at token end and returns after the gap
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tok_cnt_ff     <= `ELC_GAP_RST;
      tx_tok_ready_o <= 1'b0;
    end else if (!cfg.en || tx_token_end_i) begin
      tok_cnt_ff     <= `ELC_GAP_RST;
      tx_tok_ready_o <= 1'b0;
    end else if (!tx_tok_ready_o) begin
      tok_cnt_ff     <= tok_hit ? tok_cnt_ff : tok_nxt[10:0];    // [R12]
      tx_tok_ready_o <= tok_hit;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_rxrst_cmd; cfg.rxrst_cmd; endsequence
  sequence s_one_pulse; rx_resync_o ##1 !rx_resync_o; endsequence

  a_err_set_event: assert property (err_ev |=> err_ff) // [R4]
    else $error("error flag missed an event");
  a_err_read_clear: assert property (cfg.rd_clr && !err_ev |=> !err_ff) // [R5]
    else $error("error flag not cleared by read");
  a_init_req_sent: assert property (cfg.init_cmd && !credit_rcvd_i |=> // [R8]
      !txcr_ff && credit_req_o)
    else $error("init did not clear credit and send request");
  a_rx_resync_pulse: assert property (s_rxrst_cmd ##1 !cfg.rxrst_cmd |-> s_one_pulse) // [R10]
    else $error("receiver resync not a single pulse");
  a_sym_pace_gap: assert property (tx_sym_step_o && cfg.sym_gap > 11'h001 |=> !tx_sym_step_o) // [R11]
    else $error("symbol step faster than gap");
  a_tok_gap_wait: assert property ($rose(tx_tok_ready_o) |-> $past(tok_hit)) // [R12]
    else $error("token ready before gap elapsed");
endmodule // elc_link_unit
`default_nettype wire

// ### logic/elc_link_ctrl.sv
// Register file and per-link control for the eight external links
// What this block does
// R1 - Eight link control/status registers at indices 0x80 through 0x87.
// R2 - Bit 31 enables the link and selects owner of shared ports.
// R3 - Bit 30 selects two-wire (0) or five-wire (1) signalling.
// R4 - Error bit 27 sets on receive overflow or illegal token.
// R5 - Reading the control register clears the error bit.
// R6 - Bit 26 reads one while credit is granted to the remote end.
// R7 - Bit 25 reads one while this end holds transmit credit.
// R8 - Writing bit 24 clears transmit credit and sends a credit request.
// R9 - Remote end answers a credit request by sending credit back.
// R10 - Writing bit 23 resynchronises the receiver to a token start.
// R11 - Bits 21:11 give system clocks between transitions within a token.
// R12 - Bits 10:0 give system clocks between consecutive tokens.
// R13 - Eight static forwarding registers at indices 0xA0 through 0xA7.
// R14 - Static enable sends every received packet to the set channel end.
// R15 - Bits 4:0 select the local channel end for static traffic.
// R16 - All control fields and status bits reset to zero.
// R17 - Reserved bits read zero and ignore writes.
// R18 - Self-clearing command bits read zero and act once per write.
`include "elc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module elc_link_ctrl
  import elc_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  // Configuration access
  input  wire logic        cfg_req_i,
  input  wire logic        cfg_wr_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic             cfg_ack_o,
  output logic [31:0]      cfg_rdata_o,
  // Link datapath events, one bit per link
  input  wire logic [7:0]  rx_overflow_i,
  input  wire logic [7:0]  rx_bad_token_i,
  input  wire logic [7:0]  credit_rcvd_i,
  input  wire logic [7:0]  rx_credit_out_i,
  input  wire logic [7:0]  tx_in_token_i,
  input  wire logic [7:0]  tx_token_end_i,
  // Routed destination offered by the router, per link
  input  wire logic [39:0] route_chanend_i,
  // Link mode and commands, one bit per link
  output logic [7:0]       link_en_o,
  output logic [7:0]       five_wire_o,
  output logic [7:0]       credit_req_o,
  output logic [7:0]       rx_resync_o,
  output logic [7:0]       tx_sym_step_o,
  output logic [7:0]       tx_tok_ready_o,
  // Delivery of received packets, per link
  output logic [7:0]       fwd_static_o,
  output logic [39:0]      fwd_chanend_o
);

  // Link control fields
  logic [7:0] en_ff;
  logic [7:0] five_ff;
  elc_gap_t   sym_gap_ff [`ELC_NLINK];
  elc_gap_t   tok_gap_ff [`ELC_NLINK];

  // One-cycle command strobes, never visible on a read
  logic [7:0] init_ff;
  logic [7:0] rxrst_ff;

  // Static forwarding fields
  logic [7:0] sfwd_ff;
  elc_ce_t    sce_ff [`ELC_NLINK];

  // Read response
  logic       ack_ff;
  elc_word_t  rdata_ff;

  // Per-link read words and unit status
  elc_word_t  ctrl_word [`ELC_NLINK];
  elc_word_t  fwd_word  [`ELC_NLINK];
  logic [7:0] err_st;
  logic [7:0] txcr_st;
  logic [7:0] rxcr_st;

  // Access decode
  elc_sel_e   sel;
  logic [2:0] idx;
  logic       wr_ctrl;
  logic       wr_fwd;
  logic       rd_ctrl;
  logic [7:0] idx_hot;
  elc_word_t  rd_word;

  // Group decode; anything outside both groups answers zero
  assign sel = (cfg_addr_i >= `ELC_CTRL_BASE && cfg_addr_i <= `ELC_CTRL_LAST) ?
               ELC_SEL_CTRL :                                       // [R1]
               (cfg_addr_i >= `ELC_FWD_BASE && cfg_addr_i <= `ELC_FWD_LAST) ?
               ELC_SEL_FWD : ELC_SEL_NONE;                          // [R13]
  assign idx     = cfg_addr_i[2:0];
  assign idx_hot = 8'h01 << idx;
  assign wr_ctrl = cfg_req_i && cfg_wr_i && (sel == ELC_SEL_CTRL);
  assign wr_fwd  = cfg_req_i && cfg_wr_i && (sel == ELC_SEL_FWD);
  assign rd_ctrl = cfg_req_i && !cfg_wr_i && (sel == ELC_SEL_CTRL);

  // Read selection; the old error value is returned as it is cleared
  assign rd_word = (sel == ELC_SEL_CTRL) ? ctrl_word[idx] :
                   (sel == ELC_SEL_FWD)  ? fwd_word[idx]  : `ELC_WORD_RST;

  // Outputs taken straight from the control flops
  assign link_en_o    = en_ff;
  assign five_wire_o  = five_ff;
  assign fwd_static_o = sfwd_ff;
  assign cfg_ack_o    = ack_ff;
  assign cfg_rdata_o  = rdata_ff;

  // Enable and width bits
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_ff   <= 8'h00;   // [R16]
      five_ff <= 8'h00;
    end else if (wr_ctrl) begin
      en_ff[idx]   <= cfg_wdata_i[`ELC_B_EN];     // [R2]
      five_ff[idx] <= cfg_wdata_i[`ELC_B_FIVE];   // [R3]
    end
  end

  // Command strobes last exactly one cycle per write of one
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      init_ff  <= 8'h00;
      rxrst_ff <= 8'h00;
    end else begin
      init_ff  <= (wr_ctrl && cfg_wdata_i[`ELC_B_INIT])  ? idx_hot : 8'h00;   // [R8] [R18]
      rxrst_ff <= (wr_ctrl && cfg_wdata_i[`ELC_B_RXRST]) ? idx_hot : 8'h00;   // [R10] [R18]
    end
  end

  // Static enable bits
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) sfwd_ff <= 8'h00;   // [R16]
    else if (wr_fwd) sfwd_ff[idx] <= cfg_wdata_i[`ELC_B_FWD_EN];   // [R14]
  end

  // Response register; every access is answered one cycle later
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_ff   <= 1'b0;
      rdata_ff <= `ELC_WORD_RST;
    end else begin
      ack_ff   <= cfg_req_i;
      rdata_ff <= (cfg_req_i && !cfg_wr_i) ? rd_word : `ELC_WORD_RST;
    end
  end

  // Per-link fields, read words and link units
  genvar g;
  generate
    for (g = 0; g < `ELC_NLINK; g++) begin : g_link
      elc_cfg_if lnk ();

      // Spacing fields and channel end of this link
      always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sym_gap_ff[g] <= `ELC_GAP_RST;
          tok_gap_ff[g] <= `ELC_GAP_RST;
          sce_ff[g]     <= `ELC_CE_RST;
        end else begin
          if (wr_ctrl && idx == 3'(g)) begin
            sym_gap_ff[g] <= cfg_wdata_i[`ELC_SYM_HI:`ELC_SYM_LO];   // [R11]
            tok_gap_ff[g] <= cfg_wdata_i[`ELC_TOK_HI:`ELC_TOK_LO];   // [R12]
          end
          if (wr_fwd && idx == 3'(g)) begin
            sce_ff[g] <= cfg_wdata_i[`ELC_CE_HI:`ELC_CE_LO];         // [R15]
          end
        end
      end

      // Delivery: static links bypass the router's choice
      always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) fwd_chanend_o[g*5 +: 5] <= `ELC_CE_RST;
        else fwd_chanend_o[g*5 +: 5] <= sfwd_ff[g] ? sce_ff[g] :
                                         route_chanend_i[g*5 +: 5];   // [R14]
      end

      // Control word: reserved and command bits stay zero
      always_comb begin
        ctrl_word[g]              = `ELC_WORD_RST;   // [R17] [R18]
        ctrl_word[g][`ELC_B_EN]   = en_ff[g];
        ctrl_word[g][`ELC_B_FIVE] = five_ff[g];
        ctrl_word[g][`ELC_B_ERR]  = err_st[g];
        ctrl_word[g][`ELC_B_RXCR] = rxcr_st[g];      // [R6]
        ctrl_word[g][`ELC_B_TXCR] = txcr_st[g];      // [R7]
        ctrl_word[g][`ELC_SYM_HI:`ELC_SYM_LO] = sym_gap_ff[g];
        ctrl_word[g][`ELC_TOK_HI:`ELC_TOK_LO] = tok_gap_ff[g];
      end

      // Static word
      always_comb begin
        fwd_word[g]                         = `ELC_WORD_RST;   // [R17]
        fwd_word[g][`ELC_B_FWD_EN]          = sfwd_ff[g];
        fwd_word[g][`ELC_CE_HI:`ELC_CE_LO]  = sce_ff[g];
      end

      // Carrier toward the unit
      assign lnk.en        = en_ff[g];
      assign lnk.five      = five_ff[g];
      assign lnk.sym_gap   = sym_gap_ff[g];
      assign lnk.tok_gap   = tok_gap_ff[g];
      assign lnk.init_cmd  = init_ff[g];
      assign lnk.rxrst_cmd = rxrst_ff[g];
      assign lnk.rd_clr    = rd_ctrl && idx == 3'(g);   // [R5]
      assign err_st[g]     = lnk.err;
      assign txcr_st[g]    = lnk.tx_credit;
      assign rxcr_st[g]    = lnk.rx_credit;

      elc_link_unit u_unit (
        .mclk_i          (mclk_i),
        .rstn_i          (rstn_i),
        .cfg             (lnk.unit),
        .rx_overflow_i   (rx_overflow_i[g]),
        .rx_bad_token_i  (rx_bad_token_i[g]),
        .credit_rcvd_i   (credit_rcvd_i[g]),     // [R9]
        .rx_credit_out_i (rx_credit_out_i[g]),
        .tx_in_token_i   (tx_in_token_i[g]),
        .tx_token_end_i  (tx_token_end_i[g]),
        .credit_req_o    (credit_req_o[g]),
        .rx_resync_o     (rx_resync_o[g]),
        .tx_sym_step_o   (tx_sym_step_o[g]),
        .tx_tok_ready_o  (tx_tok_ready_o[g])
      );
    end
  endgenerate

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  // Write of a control word, and its effect one cycle on
  sequence s_ctrl_write;
    cfg_req_i && cfg_wr_i && sel == ELC_SEL_CTRL;
  endsequence

  a_cfg_read_ack: assert property (cfg_req_i |=> cfg_ack_o) // [R1]
    else $error("access not answered next cycle");
  a_ctrl_en_write: assert property (s_ctrl_write |=>
      link_en_o[$past(idx)] == $past(cfg_wdata_i[`ELC_B_EN])) // [R2]
    else $error("enable bit not written");
  a_five_wire_mode: assert property (s_ctrl_write |=>
      five_wire_o[$past(idx)] == $past(cfg_wdata_i[`ELC_B_FIVE])) // [R3]
    else $error("width bit not written");
  a_ctrl_reserved_zero: assert property (cfg_ack_o && $past(sel) == ELC_SEL_CTRL |->
      cfg_rdata_o[29:28] == 2'h0 && cfg_rdata_o[24:22] == 3'h0) // [R17] [R18]
    else $error("reserved or command bits read nonzero");
  a_fwd_reserved_zero: assert property (cfg_ack_o && $past(sel) == ELC_SEL_FWD |->
      cfg_rdata_o[30:5] == 26'h0) // [R17]
    else $error("static register reserved bits read nonzero");
  a_fwd_static_write: assert property (cfg_req_i && cfg_wr_i && sel == ELC_SEL_FWD |=>
      fwd_static_o[$past(idx)] == $past(cfg_wdata_i[`ELC_B_FWD_EN])) // [R14]
    else $error("static enable not written");
  a_static_chanend: assert property (##1 fwd_static_o[0] && $stable(fwd_static_o[0]) |=>
      fwd_chanend_o[4:0] == $past(sce_ff[0])) // [R15]
    else $error("static link not sent to its channel end");
  a_cmd_once: assert property (init_ff != 8'h00 |=> init_ff == 8'h00 ||
      $past(wr_ctrl && cfg_wdata_i[`ELC_B_INIT])) // [R18]
    else $error("init strobe held without a new write");
  a_unmapped_zero: assert property (cfg_req_i && !cfg_wr_i && sel == ELC_SEL_NONE |=>
      cfg_rdata_o == 32'h0000_0000) // [R17]
    else $error("unmapped read returned data");
endmodule // elc_link_ctrl
`default_nettype wire

// ### dv/elc_remote_peer.sv
// Behavioural far-end link endpoint that answers credit requests
`timescale 1ns/1ps
`default_nettype none
module elc_remote_peer (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rstn_i,
  // Request side
  input  wire logic [7:0] creq_i,
  input  wire logic       slow_i,
  // Answer side
  output logic      [7:0] credit_o
);
  logic [4:0] wait_ff [8];

  // Per-link countdown; slow mode lets the bench see the no-credit window
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    for (int g = 0; g < 8; g++) begin
      if (!rstn_i) begin
        wait_ff[g]  <= 5'h00;
        credit_o[g] <= 1'b0;
      end else begin
        credit_o[g] <= (wait_ff[g] == 5'h01);
        if (creq_i[g]) begin
          wait_ff[g] <= slow_i ? 5'h0C : 5'h01;
        end else if (wait_ff[g] != 5'h00) begin
          wait_ff[g] <= wait_ff[g] - 5'h01;
        end
      end
    end
  end
endmodule // elc_remote_peer
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the external link control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
  logic        mclk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        cfg_req_i = 1'b0;
  logic        cfg_wr_i = 1'b0;
  logic [7:0]  cfg_addr_i = 8'h00;
  logic [31:0] cfg_wdata_i = 32'h0;
  logic [7:0]  ovf = 8'h00;
  logic [7:0]  bad = 8'h00;
  logic [7:0]  rxcr = 8'h00;
  logic [7:0]  intok = 8'h00;
  logic [7:0]  tokend = 8'h00;
  logic [39:0] route = 40'h12_3456_789A;
  logic        slow = 1'b1;
  logic        cfg_ack_o;
  logic [31:0] cfg_rdata_o;
  logic [7:0]  credit, link_en_o, five_wire_o, credit_req_o, rx_resync_o;
  logic [7:0]  tx_sym_step_o, tx_tok_ready_o, fwd_static_o;
  logic [39:0] fwd_chanend_o;
  int          miscompares = 0;
  int          tests_run = 0;
  int          creq_cnt = 0;
  int          resync_cnt = 0;

  // Clock at 200 MHz
  always #2.5 mclk_i = ~mclk_i;

  elc_link_ctrl u_elc_link_ctrl (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .cfg_req_i(cfg_req_i), .cfg_wr_i(cfg_wr_i),
    .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_ack_o(cfg_ack_o),
    .cfg_rdata_o(cfg_rdata_o), .rx_overflow_i(ovf), .rx_bad_token_i(bad),
    .credit_rcvd_i(credit), .rx_credit_out_i(rxcr), .tx_in_token_i(intok),
    .tx_token_end_i(tokend), .route_chanend_i(route), .link_en_o(link_en_o),
    .five_wire_o(five_wire_o), .credit_req_o(credit_req_o), .rx_resync_o(rx_resync_o),
    .tx_sym_step_o(tx_sym_step_o), .tx_tok_ready_o(tx_tok_ready_o),
    .fwd_static_o(fwd_static_o), .fwd_chanend_o(fwd_chanend_o));

  elc_remote_peer u_elc_remote_peer (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .creq_i(credit_req_o), .slow_i(slow),
    .credit_o(credit));

  // Pulse counters, so a strobe that lasts two cycles is caught
  always @(posedge mclk_i) begin
    creq_cnt += $countones(credit_req_o);
    resync_cnt += $countones(rx_resync_o);
  end

  // One register access; request is taken at one edge, answer read just after it
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk_i);
    #1;
    cfg_req_i = 1'b1;
    cfg_wr_i = w;
    cfg_addr_i = a;
    cfg_wdata_i = d;
    @(posedge mclk_i);
    #1;
    cfg_req_i = 1'b0;
    q = cfg_rdata_o;
    `CHK(cfg_ack_o, 1'b1)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    `CHK(q, exp)
  endtask

  // Reset values of every register, enable, width and static outputs low, unmapped index dead
  task automatic t_reset();
    for (int g = 0; g < 8; g++) begin
      rd(8'h80 + 8'(g), 32'h0);
      rd(8'hA0 + 8'(g), 32'h0);
    end
    `CHK({link_en_o, five_wire_o, fwd_static_o}, 24'h0)
    wr(8'h88, 32'hFFFF_FFFF);
    rd(8'h88, 32'h0);
    $display("test reset done");
  endtask

  // Writable fields stick and reserved bits read zero; command bits 24 and 23 are written as zero here
  task automatic t_fields();
    for (int g = 0; g < 8; g++) begin
      wr(8'h80 + 8'(g), 32'hF07F_FFFF);
      rd(8'h80 + 8'(g), 32'hC03F_FFFF);
      `CHK({link_en_o[g], five_wire_o[g]}, 2'b11)
      wr(8'h80 + 8'(g), 32'h4000_0000);
      `CHK({link_en_o[g], five_wire_o[g]}, 2'b01)
      wr(8'h80 + 8'(g), 32'h0);
      wr(8'hA0 + 8'(g), 32'hFFFF_FFFF);
      rd(8'hA0 + 8'(g), 32'h8000_001F);
      `CHK(fwd_static_o[g], 1'b1)
      `CHK(fwd_chanend_o[5*g +: 5], 5'h1F)
      wr(8'hA0 + 8'(g), 32'h0);
      // Delivery register lags the enable by one cycle
      @(posedge mclk_i);
      #1;
      `CHK(fwd_chanend_o[5*g +: 5], route[5*g +: 5])
    end
    $display("test fields done");
  endtask

  // Sticky error set by either event, cleared by the read that shows it
  task automatic t_error(input int g, input logic which);
    @(posedge mclk_i);
    #1;
    if (which) bad[g] = 1'b1;
    else ovf[g] = 1'b1;
    @(posedge mclk_i);
    #1;
    ovf = 8'h00;
    bad = 8'h00;
    repeat (3) @(posedge mclk_i);
    rd(8'h80 + 8'(g), 32'h0800_0000);
    rd(8'h80 + 8'(g), 32'h0);
    $display("test error done");
  endtask

  // Credit request with slow and prompt far end, plus issued-credit status
  task automatic t_credit();
    int h0;
    h0 = creq_cnt;
    slow = 1'b1;
    wr(8'h80, 32'h8100_0000);
    rd(8'h80, 32'h8000_0000);
    `CHK(creq_cnt - h0, 1)
    repeat (16) @(posedge mclk_i);
    rd(8'h80, 32'h8200_0000);
    slow = 1'b0;
    wr(8'h80, 32'h8100_0000);
    repeat (4) @(posedge mclk_i);
    rd(8'h80, 32'h8200_0000);
    `CHK(creq_cnt - h0, 2)
    wr(8'h80, 32'h0);
    @(posedge mclk_i);
    #1;
    rxcr[4] = 1'b1;
    repeat (2) @(posedge mclk_i);
    rd(8'h84, 32'h0400_0000);
    rxcr[4] = 1'b0;
    repeat (2) @(posedge mclk_i);
    rd(8'h84, 32'h0);
    $display("test credit done");
  endtask

  // Receiver resynchronise strobe fires once and reads back zero
  task automatic t_rxrst();
    int r0;
    r0 = resync_cnt;
    wr(8'h83, 32'h0080_0000);
    rd(8'h83, 32'h0);
    `CHK(resync_cnt - r0, 1)
    $display("test resync done");
  endtask

  // Symbol spacing of 3 and token spacing of 4 on link 1
  task automatic t_pacing();
    int n;
    wr(8'h81, 32'h8000_1804);
    intok[1] = 1'b1;
    // Outputs are looked at just after each edge, once settled
    n = 0;
    do begin @(posedge mclk_i); #1; n++; end while (!tx_sym_step_o[1] && n < 50);
    n = 0;
    do begin @(posedge mclk_i); #1; n++; end while (!tx_sym_step_o[1] && n < 50);
    `CHK(n, 3)
    `CHK(tx_tok_ready_o[1], 1'b1)
    intok[1] = 1'b0;
    tokend[1] = 1'b1;
    @(posedge mclk_i);
    #1;
    tokend[1] = 1'b0;
    `CHK(tx_tok_ready_o[1], 1'b0)
    n = 0;
    do begin @(posedge mclk_i); #1; n++; end while (!tx_tok_ready_o[1] && n < 50);
    `CHK(n, 4)
    wr(8'h81, 32'h0);
    $display("test pacing done");
  endtask

  // Reset in mid-run wipes written fields and static enables
  task automatic t_midreset();
    wr(8'h85, 32'hC000_0FFF);
    wr(8'hA5, 32'h8000_0007);
    @(posedge mclk_i);
    #1;
    rstn_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    rstn_i = 1'b1;
    `CHK({link_en_o[5], five_wire_o[5], fwd_static_o[5]}, 3'b000)
    rd(8'h85, 32'h0);
    rd(8'hA5, 32'h0);
    $display("test midreset done");
  endtask

  task automatic end_sim();
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog, far beyond the expected few hundred cycles
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge mclk_i);
    #1;
    rstn_i = 1'b1;
    t_reset();
    t_fields();
    t_error(2, 1'b0);
    t_error(5, 1'b1);
    t_credit();
    t_rxrst();
    t_pacing();
    t_midreset();
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
